// ### core/mac_port_mode_params.svh
// Constants for the two-port MAC mode selector
// Notes on behaviour
// - There are two independent ports, each MAC able to run at 10G, 1G, 100M or 10M.
// - Each port has its own MAC and both coding sublayers, with one shared management master and SerDes control.
// - The only 10G attachment offered is XAUI.
// - The per-port mode bits pick both the MAC clock source and the data path.
// - Every mode and loopback bit except the chip-wide blunt-end wrap exists once per port, indexed by port number.
// - Dual 10G XAUI sets the 10G select, clears the 1G and 100/10M selects and clears bypass.
// - Mixed mode runs port 0 as 10G XAUI and port 1 as optical 1G with bypass cleared.
// - Dual optical 1G sets the 1G select, clears the others and clears bypass.
// - MAC wrap set with sublayer wrap clear loops the port back at the MAC.
// - MAC wrap clear with sublayer wrap set loops the port back inside the 10G sublayer.
// - The chip-wide blunt-end wrap loops both 10G and 1G with per-port wraps clear.
// - Write-zero-clear fields clear on a 0, write-one-clear fields on a 1, others unchanged.
// - Auto-clear fields read back and return to 0 once their action is taken.
`ifndef MAC_PORT_MODE_PARAMS_SVH
`define MAC_PORT_MODE_PARAMS_SVH
`define NUM_PORTS      2
`define SPEED_10G      2'h3
`define SPEED_1G       2'h2
`define SPEED_100M     2'h1
`define SPEED_10M      2'h0
`define CLK_SRC_XAUI   2'h0
`define CLK_SRC_SERDES 2'h1
`define CLK_SRC_PHY    2'h2
`define CLK_SRC_NONE   2'h3
`endif

// ### core/mac_port_mode_pkg.sv
// Types for the two-port MAC mode selector
package mac_port_mode_pkg;
    typedef enum logic [2:0] {
        path_off,
        path_xaui,
        path_serdes_1g,
        path_phy_bypass,
        path_mac_wrap,
        path_sublayer_wrap,
        path_blunt_wrap
    } data_path_t;

    typedef struct packed {
        logic ten_gig_sel;
        logic one_gig_sel;
        logic slow_sel;
        logic sublayer_bypass;
        logic mac_level_wrap;
        logic ten_gig_sublayer_wrap;
        logic [1:0] speed;
    } port_mode_t;

    typedef struct packed {
        data_path_t path;
        logic [1:0] clk_src;
        logic       config_err;
    } port_route_t;

    typedef struct packed {
        logic w0c_flag;
        logic w1c_flag;
        logic auto_clear;
    } port_flags_t;

    typedef struct packed {
        port_route_t [1:0] route;
        port_flags_t [1:0] flags;
        logic        [1:0] action_pulse;
        logic              speed_mismatch;
    } mode_state_t;
endpackage

// ### core/mac_port_mode_config.sv
// Per-port mode, clock source and loopback selection for the two MAC ports
`timescale 1ns/100ps
`include "mac_port_mode_params.svh"
module mac_port_mode_config (
    // Clock and reset
    input  wire logic                                 clk_sys_i,
    input  wire logic                                 resetn_i,
    // Per-port mode bits and chip-wide blunt-end wrap
    input  wire mac_port_mode_pkg::port_mode_t [1:0]  port_mode_i,
    input  wire logic                                 blunt_end_wrap_i,
    // Flag events and software clear strobes
    input  wire logic [1:0]                           flag_event_i,
    input  wire logic [1:0]                           w0c_write_i,
    input  wire logic [1:0]                           w0c_data_i,
    input  wire logic [1:0]                           w1c_write_i,
    input  wire logic [1:0]                           w1c_data_i,
    input  wire logic [1:0]                           auto_clear_set_i,
    input  wire logic [1:0]                           action_done_i,
    // Routing results
    output mac_port_mode_pkg::port_route_t [1:0]      port_route_o,
    output mac_port_mode_pkg::port_flags_t [1:0]      port_flags_o,
    output logic [1:0]                                action_pulse_o,
    output logic                                      speed_mismatch_o
);
    import mac_port_mode_pkg::*;

    mode_state_t state;
    mode_state_t next_state;

    always_comb begin
        next_state = state;
        for (int p = 0; p < `NUM_PORTS; p++) begin
            // Clock source and data path from the mode bits
            next_state.route[p].config_err = 1'b0;
            if (blunt_end_wrap_i) begin
                next_state.route[p].path = path_blunt_wrap;
                next_state.route[p].clk_src = port_mode_i[p].ten_gig_sel ?
                    `CLK_SRC_XAUI : `CLK_SRC_SERDES;
            end else if (port_mode_i[p].mac_level_wrap
                         && !port_mode_i[p].ten_gig_sublayer_wrap) begin
                next_state.route[p].path = path_mac_wrap;
                next_state.route[p].clk_src = `CLK_SRC_XAUI;
            end else if (!port_mode_i[p].mac_level_wrap
                         && port_mode_i[p].ten_gig_sublayer_wrap) begin
                next_state.route[p].path = path_sublayer_wrap;
                next_state.route[p].clk_src = `CLK_SRC_XAUI;
            end else if (port_mode_i[p].ten_gig_sel && !port_mode_i[p].one_gig_sel
                         && !port_mode_i[p].slow_sel
                         && !port_mode_i[p].sublayer_bypass) begin
                next_state.route[p].path = path_xaui;
                next_state.route[p].clk_src = `CLK_SRC_XAUI;
            end else if (port_mode_i[p].one_gig_sel && !port_mode_i[p].ten_gig_sel
                         && !port_mode_i[p].slow_sel) begin
                next_state.route[p].path = port_mode_i[p].sublayer_bypass ?
                    path_phy_bypass : path_serdes_1g;
                next_state.route[p].clk_src = port_mode_i[p].sublayer_bypass ?
                    `CLK_SRC_PHY : `CLK_SRC_SERDES;
            end else if (port_mode_i[p].slow_sel && !port_mode_i[p].ten_gig_sel
                         && !port_mode_i[p].one_gig_sel) begin
                next_state.route[p].path = path_phy_bypass;
                next_state.route[p].clk_src = `CLK_SRC_PHY;
            end else begin
                next_state.route[p].path = path_off;
                next_state.route[p].clk_src = `CLK_SRC_NONE;
                next_state.route[p].config_err = 1'b1;
            end
            if (port_mode_i[p].mac_level_wrap && port_mode_i[p].ten_gig_sublayer_wrap) begin
                next_state.route[p].config_err = 1'b1;
            end
            // Write-zero and write-one clear, set wins
            if (w0c_write_i[p] && !w0c_data_i[p]) begin
                next_state.flags[p].w0c_flag = 1'b0;
            end
            if (w1c_write_i[p] && w1c_data_i[p]) begin
                next_state.flags[p].w1c_flag = 1'b0;
            end
            if (flag_event_i[p]) begin
                next_state.flags[p].w0c_flag = 1'b1;
                next_state.flags[p].w1c_flag = 1'b1;
            end
            // Auto-clear once the action is taken
            next_state.action_pulse[p] = 1'b0;
            if (state.flags[p].auto_clear && action_done_i[p]) begin
                next_state.flags[p].auto_clear = 1'b0;
                next_state.action_pulse[p] = 1'b1;
            end
            if (auto_clear_set_i[p]) begin
                next_state.flags[p].auto_clear = 1'b1;
            end
        end
        // Flag when the two ports are not at one speed
        next_state.speed_mismatch = (port_mode_i[0].speed != port_mode_i[1].speed);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign port_route_o     = state.route;
    assign port_flags_o     = state.flags;
    assign action_pulse_o   = state.action_pulse;
    assign speed_mismatch_o = state.speed_mismatch;
endmodule

// ### verif/mac_port_mode_assertions.sv
// Assertions on the MAC port mode selector
`timescale 1ns/100ps
`include "mac_port_mode_params.svh"
module mac_port_mode_chk import mac_port_mode_pkg::*; (
    input wire logic              clk_sys_i, resetn_i, blunt_end_wrap_i, speed_mismatch_o,
    input wire port_mode_t  [1:0] port_mode_i,
    input wire logic        [1:0] flag_event_i, w0c_write_i, w0c_data_i, w1c_write_i,
    input wire logic        [1:0] w1c_data_i, auto_clear_set_i, action_done_i, action_pulse_o,
    input wire port_route_t [1:0] port_route_o,
    input wire port_flags_t [1:0] port_flags_o);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    sequence ac_done(p);
        port_flags_o[p].auto_clear && action_done_i[p] && !auto_clear_set_i[p];
    endsequence
    speed_flag_a: assert property (
        port_mode_i[0][1:0] != port_mode_i[1][1:0] |=> speed_mismatch_o) else $error("speed");
    xaui_route_a: assert property (
        port_mode_i[0][7:2] == 6'h20 && !blunt_end_wrap_i
        |=> port_route_o[0] == {path_xaui, `CLK_SRC_XAUI, 1'b0}) else $error("xaui");
    optical_route_a: assert property (
        port_mode_i[1][7:2] == 6'h10 && !blunt_end_wrap_i
        |=> port_route_o[1] == {path_serdes_1g, `CLK_SRC_SERDES, 1'b0}) else $error("optical");
    mac_wrap_a: assert property (
        port_mode_i[0][3:2] == 2'h2 && !blunt_end_wrap_i
        |=> port_route_o[0].path == path_mac_wrap) else $error("mac wrap");
    sublayer_wrap_a: assert property (
        port_mode_i[1][3:2] == 2'h1 && !blunt_end_wrap_i
        |=> port_route_o[1].path == path_sublayer_wrap) else $error("sublayer wrap");
    blunt_wrap_a: assert property (blunt_end_wrap_i |=>
        port_route_o[0].path == path_blunt_wrap && port_route_o[1].path == path_blunt_wrap)
        else $error("blunt");
    w1c_clear_a: assert property (w1c_write_i[0] && w1c_data_i[0] && !flag_event_i[0]
        |=> !port_flags_o[0].w1c_flag) else $error("w1c");
    auto_done_a: assert property (ac_done(0) |=>
        action_pulse_o[0] && !port_flags_o[0].auto_clear) else $error("auto");
endmodule
bind mac_port_mode_config mac_port_mode_chk chk_u (.*);

// ### verif/far_side_model.sv
// Far side: acknowledges triggered actions and forwards link events
`timescale 1ns/100ps
module far_side_model import mac_port_mode_pkg::*; (
    input  wire logic              clk_sys_i,
    input  wire port_flags_t [1:0] flags_i,
    input  wire logic        [1:0] ev_i,
    output logic             [1:0] done_o,
    output logic             [1:0] event_o);
    initial {done_o, event_o} = '0;
    always @(posedge clk_sys_i) begin
        done_o  <= {flags_i[1].auto_clear, flags_i[0].auto_clear};
        event_o <= ev_i;
    end
endmodule

// ### verif/mac_port_mode_config_tb_top.sv
// Testbench for the MAC port mode selector
`timescale 1ns/100ps
module mac_port_mode_config_tb_top;
    import mac_port_mode_pkg::*;
    logic clk_sys_i = 0, resetn_i = 0, blunt = 0, mism;
    logic [1:0] ev = 0, evd, done, pulse, w0w = 0, w1w = 0, acs = 0, wd = 0;
    port_mode_t [1:0] mode = '0;
    port_route_t [1:0] route;
    port_flags_t [1:0] flags;
    int err_total = 0, num_checks = 0, cyc = 0, p, i, s0, s1;
    bit w0, w1, ac;
    int m0[8] = '{32, 32, 16, 34, 33, 32, 35, 20}, m1[8] = '{32, 16, 16, 34, 33, 32, 0, 8};
    int q0[8] = '{1, 1, 2, 4, 5, 6, 1, 3}, q1[8] = '{1, 2, 2, 4, 5, 6, 0, 3};
    always #10 clk_sys_i = ~clk_sys_i;
    mac_port_mode_config dut_u (.clk_sys_i, .resetn_i, .port_mode_i(mode),
        .blunt_end_wrap_i(blunt), .flag_event_i(evd), .w0c_write_i(w0w), .w0c_data_i(wd),
        .w1c_write_i(w1w), .w1c_data_i(wd), .auto_clear_set_i(acs), .action_done_i(done),
        .port_route_o(route), .port_flags_o(flags), .action_pulse_o(pulse),
        .speed_mismatch_o(mism));
    far_side_model side_u (.clk_sys_i, .flags_i(flags), .ev_i(ev), .done_o(done), .event_o(evd));
    task chk(logic [7:0] seen, logic [7:0] exp, string nm);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task wr(int k);
        @(posedge clk_sys_i);
        {w0w[p], w1w[p], acs[p], wd[p]} <= {k == 0, k == 1, k == 2, i > 2};
        @(posedge clk_sys_i);
        {w0w, w1w, acs} <= 6'h0;
        @(negedge clk_sys_i);
        w0 &= !(k == 0 && i < 3);
        w1 &= !(k == 1 && i > 2);
        ac |= k == 2;
        chk(flags[p], {w0, w1, ac}, "flags");
        if (k == 2) begin
            repeat (2) @(posedge clk_sys_i);
            @(negedge clk_sys_i);
            ac = 0;
            chk({pulse[p], flags[p]}, {1'b1, w0, w1, ac}, "auto");
        end
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc > 500) begin
            err_total++;
            end_sim;
        end
    end
    initial begin
        void'($urandom(13239));
        repeat (5) @(posedge clk_sys_i);
        resetn_i <= 1;
        for (i = 0; i < 8; i++) begin
            s0 = $urandom % 4;
            s1 = $urandom % 4;
            @(posedge clk_sys_i);
            mode <= {6'(m1[i]), 2'(s1), 6'(m0[i]), 2'(s0)};
            blunt <= i == 5;
            @(posedge clk_sys_i);
            @(negedge clk_sys_i);
            chk(route[0].path, 8'(q0[i]), "path0");
            chk(route[1].path, 8'(q1[i]), "path1");
            chk(mism, s0 != s1, "speed");
            if (i < 3) chk(route[0][2:0], q0[i] == 2 ? 3'h2 : 3'h0, "clk0");
            if (i < 3) chk(route[1][2:0], q1[i] == 2 ? 3'h2 : 3'h0, "clk1");
            if (i > 5) chk(route[0][2:0], i == 6 ? 3'h1 : 3'h4, "clk0x");
            if (i > 5) chk(route[1][2:0], i == 6 ? 3'h7 : 3'h4, "clk1x");
        end
        @(posedge clk_sys_i);
        resetn_i <= 0;
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk({mism, route[0]}, 8'h0, "reset0");
        chk(route[1], 8'h0, "reset1");
        @(posedge clk_sys_i);
        resetn_i <= 1;
        $display("mode tests done");
        for (p = 0; p < 2; p++) begin
            @(posedge clk_sys_i);
            ev[p] <= 1;
            @(posedge clk_sys_i);
            ev <= 0;
            repeat (2) @(posedge clk_sys_i);
            {w0, w1, ac} = 3'h6;
            for (i = 0; i < 6; i++) wr(i % 3);
        end
        $display("flag tests done");
        end_sim;
    end
endmodule
